// *** verilog/rdm_pkg.sv ***
// Functional notes
// RL1: in multiplexed mode with decoding bypassed the A/B bit-9 output carries bit 10 of each word.
// RL2: in nibble mode with decoding bypassed the A/B bit-9 output carries bit 5 then bit 10 of channel B.
// RL3: the C/D bit-9 output does the same for the C/D pair and channel D.
// RL4: receive data is presented on both edges of the receive clock, two values per period on each pin.
// RL5: in multiplexed mode channel D sits on the rising edge of the C/D bus and channel C on the falling edge.
// RL6: in multiplexed mode channel F sits on the rising edge of the E/F bus and channel E on the falling edge.
// RL7: in nibble mode the low nibble goes out on the falling edge and the high nibble on the next rising edge.
// RL8: in nibble mode channel C uses bits 4 to 0 of the C/D bus and channel D bits 9 to 5.
// RL9: in nibble mode with decoding on, C/D bit 3 is channel C's control flag in the rising-edge half.
// RL10: in multiplexed mode with decoding bypassed the C/D bit-8 output carries bit 9 of each word.
// RL11: in multiplexed mode with decoding on, C/D bit 8 is high exactly when bits 7 to 0 hold a control character.
// RL12: in nibble mode with decoding bypassed C/D bit 8 carries bit 4 then bit 9 of channel D.
// RL13: in nibble mode with decoding on, C/D bit 8 is channel D data bit 3 falling and its control flag rising.
// RL14: the protocol device captures on both edges, the rising value as the upper-lettered channel; the bench model latches both halves on the rising edge only.
// RL15: the receive clock is a buffered copy of the reference clock and the partner latches with it.
// RL16: in nibble mode channel A uses bits 4 to 0 of the A/B bus and channel B bits 9 to 5.
// RL17: with decoding on, a bit-9 output without meaning is driven low.
`default_nettype none
package rdm_pkg;
  // word and field layout
  localparam int WORD_W    = 10;
  localparam int HALF_W    = 5;
  localparam int EF_W      = 8;
  localparam int KFLAG_POS = 8;
  localparam int NIB_KPOS  = 3;
  localparam int BUF_DEPTH = 2;
  // values after reset
  localparam logic [1:0]        SYNC_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 10'h000;

  // one received word per channel; with decoding on, bit 8 is the control flag
  typedef struct packed {
    logic [WORD_W-1:0] chF;
    logic [WORD_W-1:0] chE;
    logic [WORD_W-1:0] chD;
    logic [WORD_W-1:0] chC;
    logic [WORD_W-1:0] chB;
    logic [WORD_W-1:0] chA;
  } rdm_words_s;

  // the two halves of one pair bus for one receive clock period
  typedef struct packed {
    logic [WORD_W-1:0] rise;
    logic [WORD_W-1:0] fall;
  } rdm_pair_s;

  typedef struct packed {
    logic [EF_W-1:0] rise;
    logic [EF_W-1:0] fall;
  } rdm_ef_s;

  localparam rdm_words_s WORDS_RST = '0;
  localparam rdm_pair_s  PAIR_RST  = '0;
  localparam rdm_ef_s    EF_RST    = '0;
endpackage : rdm_pkg
`default_nettype wire

// *** verilog/rdm_pair_buf.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdm_pair_buf (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstN,
  // filling side
  input  wire rdm_pkg::rdm_words_s inData,
  input  wire logic          inValid,
  output var  logic          inReady,
  // draining side
  output var  rdm_pkg::rdm_words_s outData,
  output var  logic          outValid,
  input  wire logic          outReady
);
  import rdm_pkg::*;

  typedef struct packed {
    rdm_words_s [BUF_DEPTH-1:0] mem;
    logic                       wrPtr;
    logic                       rdPtr;
    logic [1:0]                 count;
    logic                       ready;
  } rdm_buf_s;

  rdm_buf_s st_q;
  rdm_buf_s st_d;
  logic     doWr;
  logic     doRd;

  // push and pop; ready is a flop that resets low, so the source sees
  // no ready during reset and only a registered one afterwards
  always_comb begin
    st_d = st_q;
    doWr = inValid && st_q.ready;
    doRd = outReady && (st_q.count != 2'h0);
    if (doWr) begin
      st_d.mem[st_q.wrPtr] = inData;
      st_d.wrPtr           = ~st_q.wrPtr;
    end
    if (doRd) begin
      st_d.rdPtr = ~st_q.rdPtr;
    end
    st_d.count = st_q.count + {1'b0, doWr} - {1'b0, doRd};
    st_d.ready = (st_d.count != 2'(BUF_DEPTH));
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign inReady  = st_q.ready;
  assign outValid = (st_q.count != 2'h0);
  assign outData  = st_q.mem[st_q.rdPtr];
endmodule : rdm_pair_buf
`default_nettype wire

// *** verilog/rdm_rx_ddr_map.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdm_rx_ddr_map (
  // core clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // receive clock, buffered copy of the reference
  input  wire logic          reference_clock_in,
  // mode straps from pins
  input  wire logic          nibbleMode,
  input  wire logic          codeEnable,
  // received words from the decode stage
  input  wire rdm_pkg::rdm_words_s rxWords,
  input  wire logic          rxValid,
  output var  logic          rxReady,
  // A/B pair bus halves
  output var  rdm_pkg::rdm_pair_s abPairRxBus,
  // C/D pair bus halves
  output var  rdm_pkg::rdm_pair_s cdPairRxBus,
  // E/F pair bus halves, bits 7 to 0
  output var  rdm_pkg::rdm_ef_s   efPairRxBus,
  // one receive clock period per new word
  output var  logic          rxWordNew
);
  import rdm_pkg::*;

  // ------------------------------------------------------------------
  // reset release, one copy per clock domain
  // ------------------------------------------------------------------
  logic [1:0] coreRst_q;
  logic [1:0] linkRst_q;
  logic       coreRstN;
  logic       linkRstN;

  // core copy of the reset, released after two edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreRst_q <= SYNC_RST;
    end else begin
      coreRst_q <= {coreRst_q[0], 1'b1};
    end
  end

  // link copy; the link clock is the reference input and runs free from the core clock
  always_ff @(posedge reference_clock_in or negedge arst_n) begin
    if (!arst_n) begin
      linkRst_q <= SYNC_RST;
    end else begin
      linkRst_q <= {linkRst_q[0], 1'b1};
    end
  end

  assign coreRstN = coreRst_q[1];
  assign linkRstN = linkRst_q[1];

  // ------------------------------------------------------------------
  // two-entry buffer between the decode stage and the crossing
  // ------------------------------------------------------------------
  rdm_words_s bufData;
  logic       bufValid;
  logic       bufReady;

  rdm_pair_buf u_buf (
    .clk      (core_clk),
    .rstN     (coreRstN),
    .inData   (rxWords),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufReady)
  );

  // ------------------------------------------------------------------
  // link state, declared early because the core side reads its ack
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reqSync;
    logic       reqSeen;
    logic       ackTgl;
    logic [1:0] nibSync;
    logic [1:0] codeSync;
    rdm_pair_s  ab;
    rdm_pair_s  cd;
    rdm_ef_s    ef;
    logic       newWord;
  } rdm_link_s;

  rdm_link_s ls_q;
  rdm_link_s ls_d;

  // ------------------------------------------------------------------
  // core side of the word handshake
  // ------------------------------------------------------------------
  typedef struct packed {
    rdm_words_s hold;
    logic       reqTgl;
    logic [1:0] ackSync;
  } rdm_core_s;

  rdm_core_s cs_q;
  rdm_core_s cs_d;
  logic      pending;

  // a word is in flight until the link echoes the toggle back
  assign pending = (cs_q.ackSync[1] != cs_q.reqTgl);

  // hold stays frozen while pending, so the link reads a stable word
  assign bufReady = !pending;

  // launch a new word when the previous one has been taken
  always_comb begin
    cs_d         = cs_q;
    cs_d.ackSync = {cs_q.ackSync[0], ls_q.ackTgl};
    if (!pending && bufValid) begin
      cs_d.hold   = bufData;
      cs_d.reqTgl = ~cs_q.reqTgl;
    end
  end

  always_ff @(posedge core_clk or negedge coreRstN) begin
    if (!coreRstN) begin
      cs_q <= '0;
    end else begin
      cs_q <= cs_d;
    end
  end

  // ------------------------------------------------------------------
  // pin mapping of one word, selected by mode and decode
  // ------------------------------------------------------------------

  // full 10-bit value of one channel in multiplexed mode
  function automatic logic [WORD_W-1:0] muxVal(
    input logic [WORD_W-1:0] w,
    input logic              code
  );
    logic [WORD_W-1:0] v;
    v = w;                                   // RL1 RL10
    if (code) begin
      v = {1'b0, w[KFLAG_POS:0]};            // RL11 RL17
    end
    return v;
  endfunction : muxVal

  // falling-edge half: low nibble
  function automatic logic [HALF_W-1:0] nibFall(
    input logic [WORD_W-1:0] w,
    input logic              code
  );
    logic [HALF_W-1:0] v;
    v = w[HALF_W-1:0];                       // RL2 RL12
    if (code) begin
      v = {1'b0, w[NIB_KPOS:0]};             // RL13 RL17
    end
    return v;
  endfunction : nibFall

  // rising-edge half: high nibble, flag at position 3 when decoding
  function automatic logic [HALF_W-1:0] nibRise(
    input logic [WORD_W-1:0] w,
    input logic              code
  );
    logic [HALF_W-1:0] v;
    v = w[WORD_W-1:HALF_W];                  // RL2 RL12
    if (code) begin
      v = {1'b0, w[KFLAG_POS], w[6:4]};      // RL9 RL13 RL17
    end
    return v;
  endfunction : nibRise

  // lower-lettered channel lo, upper-lettered channel hi
  function automatic rdm_pair_s mapPair(
    input logic [WORD_W-1:0] lo,
    input logic [WORD_W-1:0] hi,
    input logic              nib,
    input logic              code
  );
    rdm_pair_s p;
    p = PAIR_RST;
    if (nib) begin
      // low channel on bits 4..0, high channel on bits 9..5
      p.fall = {nibFall(hi, code), nibFall(lo, code)};  // RL7 RL8 RL16
      p.rise = {nibRise(hi, code), nibRise(lo, code)};  // RL7 RL8 RL16
    end else begin
      // upper channel rising, lower channel falling
      p.rise = muxVal(hi, code);             // RL5 RL14
      p.fall = muxVal(lo, code);             // RL5 RL14
    end
    return p;
  endfunction : mapPair

  // ------------------------------------------------------------------
  // link side, on the receive clock
  // ------------------------------------------------------------------
  localparam int NPAIR = 3;  // A/B, C/D and E/F buses

  rdm_pair_s [NPAIR-1:0] pairMap;
  logic                  nibNow;
  logic                  codeNow;

  // straps are read only after both synchroniser stages
  assign nibNow  = ls_q.nibSync[1];
  assign codeNow = ls_q.codeSync[1];

  // one mapper per pair bus; the held word is frozen while a request is
  // pending, so it crosses as a stable bundle without its own synchroniser
  for (genvar g = 0; g < NPAIR; g++) begin : g_pair
    localparam int LO_POS = 2 * g * WORD_W;
    localparam int HI_POS = LO_POS + WORD_W;
    assign pairMap[g] = mapPair(cs_q.hold[LO_POS +: WORD_W], cs_q.hold[HI_POS +: WORD_W],
                                nibNow, codeNow);  // RL5 RL6 RL14
  end

  // take a word when the request toggle has moved, then echo it
  always_comb begin
    ls_d          = ls_q;
    ls_d.reqSync  = {ls_q.reqSync[0], cs_q.reqTgl};
    ls_d.nibSync  = {ls_q.nibSync[0], nibbleMode};
    ls_d.codeSync = {ls_q.codeSync[0], codeEnable};
    ls_d.newWord  = 1'b0;
    if (ls_q.reqSync[1] != ls_q.reqSeen) begin
      ls_d.reqSeen = ls_q.reqSync[1];
      ls_d.ackTgl  = ls_q.reqSync[1];
      ls_d.ab      = pairMap[0];                  // RL1 RL2
      ls_d.cd      = pairMap[1];                  // RL3 RL5
      // only the low eight E/F pins are carried here
      ls_d.ef.rise = pairMap[2].rise[EF_W-1:0];   // RL6
      ls_d.ef.fall = pairMap[2].fall[EF_W-1:0];   // RL6
      ls_d.newWord = 1'b1;
    end
  end

  // halves stay until the next word; the pad cell
  // launches fall then rise, two values per period
  always_ff @(posedge reference_clock_in or negedge linkRstN) begin  // RL4 RL15
    if (!linkRstN) begin
      ls_q <= '0;
    end else begin
      ls_q <= ls_d;
    end
  end

  // outputs straight from link flops
  assign abPairRxBus = ls_q.ab;
  assign cdPairRxBus = ls_q.cd;
  assign efPairRxBus = ls_q.ef;
  assign rxWordNew   = ls_q.newWord;
endmodule : rdm_rx_ddr_map
`default_nettype wire

// *** test/rdm_rx_ddr_map_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdm_rx_ddr_map_chk (
  // clocks and reset
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              reference_clock_in,
  // straps and handshake
  input wire logic              nibbleMode,
  input wire logic              codeEnable,
  input wire logic              rxValid,
  input wire logic              rxReady,
  // link outputs
  input wire rdm_pkg::rdm_pair_s abPairRxBus,
  input wire rdm_pkg::rdm_pair_s cdPairRxBus,
  input wire rdm_pkg::rdm_ef_s   efPairRxBus,
  input wire logic              rxWordNew
);
  import rdm_pkg::*;
  logic [2:0] stableCnt_q;
  logic [1:0] strap_q;
  logic       tookAny_q;
  logic       judged;
  // a strap change needs a few link cycles to reach the mapper, so skip those words
  always_ff @(posedge reference_clock_in or negedge arst_n) begin
    if (!arst_n) begin
      strap_q     <= 2'h0;
      stableCnt_q <= 3'h0;
    end else begin
      strap_q     <= {nibbleMode, codeEnable};
      stableCnt_q <= (strap_q != {nibbleMode, codeEnable}) ? 3'h0 : stableCnt_q + {2'h0, stableCnt_q != 3'h7};
    end
  end
  // remembers that at least one word was taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tookAny_q <= 1'b0;
    end else if (rxValid && rxReady) begin
      tookAny_q <= 1'b1;
    end
  end
  assign judged = rxWordNew && (stableCnt_q > 3'h3);
  sequence s_wake;
    !rxReady ##1 !rxReady;
  endsequence
  a_ready_wake: assert property (@(posedge core_clk) disable iff (!arst_n) $rose(arst_n) |-> s_wake)
    else $error("ready rose too soon after reset");
  a_word_pulse: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    rxWordNew |=> !rxWordNew) else $error("word marker longer than one cycle");
  a_bus_hold: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    !rxWordNew |-> $stable(abPairRxBus) && $stable(cdPairRxBus) && $stable(efPairRxBus))
    else $error("buses moved without a new word");
  a_new_after_take: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    rxWordNew |-> tookAny_q) else $error("word shown before any was taken");
  a_ab_bit9_low: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    judged && codeEnable |-> !abPairRxBus.rise[9] && !abPairRxBus.fall[9]) else $error("ab bit9 not low");
  a_cd_bit9_low: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    judged && codeEnable |-> !cdPairRxBus.rise[9] && !cdPairRxBus.fall[9]) else $error("cd bit9 not low");
  a_nib_fall_bit4: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    judged && nibbleMode && codeEnable |-> !abPairRxBus.fall[4] && !cdPairRxBus.fall[4])
    else $error("nibble fall bit4 not low");
  a_nib_rise_bit4: assert property (@(posedge reference_clock_in) disable iff (!arst_n)
    judged && nibbleMode && codeEnable |-> !abPairRxBus.rise[4] && !cdPairRxBus.rise[4])
    else $error("nibble rise bit4 not low");
endmodule : rdm_rx_ddr_map_chk
bind rdm_rx_ddr_map rdm_rx_ddr_map_chk rdm_rx_ddr_map_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
  .reference_clock_in(reference_clock_in), .nibbleMode(nibbleMode), .codeEnable(codeEnable),
  .rxValid(rxValid), .rxReady(rxReady), .abPairRxBus(abPairRxBus), .cdPairRxBus(cdPairRxBus),
  .efPairRxBus(efPairRxBus), .rxWordNew(rxWordNew));
`default_nettype wire

// *** test/rdm_mac_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdm_mac_model (
  // receive clock and word marker
  input  wire logic               reference_clock_in,
  input  wire logic               rxWordNew,
  // pair buses from the device
  input  wire rdm_pkg::rdm_pair_s abPairRxBus,
  input  wire rdm_pkg::rdm_pair_s cdPairRxBus,
  input  wire rdm_pkg::rdm_ef_s   efPairRxBus,
  // captured word for the bench
  output var  logic [55:0]        gotWord,
  output var  logic               gotStb
);
  import rdm_pkg::*;
  // latches both halves on the forwarded receive clock, upper channel from rise
  always @(posedge reference_clock_in) begin
    gotStb  <= rxWordNew;
    gotWord <= rxWordNew ? {abPairRxBus, cdPairRxBus, efPairRxBus} : gotWord;
  end
endmodule : rdm_mac_model
`default_nettype wire

// *** test/rdm_rx_ddr_map_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdm_rx_ddr_map_tb;
  import rdm_pkg::*;
  logic        core_clk, arst_n, reference_clock_in, nibbleMode, codeEnable, rxValid, rxReady;
  logic        rxWordNew, gotStb, sawFull;
  rdm_words_s  rxWords;
  rdm_pair_s   abPairRxBus, cdPairRxBus;
  rdm_ef_s     efPairRxBus;
  logic [55:0] gotWord;
  logic [55:0] expQ[$];
  int          nErrors, nTests, cycles;

  rdm_rx_ddr_map rdm_rx_ddr_map_inst (.core_clk(core_clk), .arst_n(arst_n),
    .reference_clock_in(reference_clock_in), .nibbleMode(nibbleMode), .codeEnable(codeEnable),
    .rxWords(rxWords), .rxValid(rxValid), .rxReady(rxReady), .abPairRxBus(abPairRxBus),
    .cdPairRxBus(cdPairRxBus), .efPairRxBus(efPairRxBus), .rxWordNew(rxWordNew));
  rdm_mac_model rdm_mac_model_inst (.reference_clock_in(reference_clock_in), .rxWordNew(rxWordNew),
    .abPairRxBus(abPairRxBus), .cdPairRxBus(cdPairRxBus), .efPairRxBus(efPairRxBus),
    .gotWord(gotWord), .gotStb(gotStb));

  // core clock, and a link clock offset so the two never keep step
  always #20 core_clk = ~core_clk;
  initial begin
    reference_clock_in = 1'b0;
    #7;
    forever #15 reference_clock_in = ~reference_clock_in;
  end

  task automatic checkWord(input logic [55:0] got, input logic [55:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : checkWord
  task automatic checkBit(input logic got, input string msg);
    nTests++;
    if (got !== 1'b1) begin
      nErrors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : checkBit

  // one pair bus for a period: {rise, fall}; the straps pick the layout
  function automatic logic [19:0] mapPair(input logic [9:0] lo, input logic [9:0] hi);
    if (!nibbleMode)
      return codeEnable ? {1'b0, hi[8:0], 1'b0, lo[8:0]} : {hi, lo};
    return codeEnable ? {1'b0, hi[8], hi[6:4], 1'b0, lo[8], lo[6:4], 1'b0, hi[3:0], 1'b0, lo[3:0]}
                      : {hi[9:5], lo[9:5], hi[4:0], lo[4:0]};
  endfunction : mapPair

  // queue the expectation, then hold the word until the buffer takes it
  task automatic send(input rdm_words_s w);
    logic [19:0] ef;
    ef = mapPair(w.chE, w.chF);
    expQ.push_back({mapPair(w.chA, w.chB), mapPair(w.chC, w.chD), ef[17:10], ef[7:0]});
    @(negedge core_clk);
    rxWords = w;
    rxValid = 1'b1;
    while (rxReady !== 1'b1) begin
      sawFull = 1'b1;
      @(negedge core_clk);
    end
    @(posedge core_clk);
  endtask : send
  task automatic drain();
    @(negedge core_clk);
    rxValid = 1'b0;
    for (int i = 0; i < 80 && expQ.size() != 0; i++) @(negedge core_clk);
    checkBit(expQ.size() == 0, "words missing");
  endtask : drain
  // straps pass a two-stage synchroniser before the mapper sees them
  task automatic mode(input logic nib, input logic code);
    @(negedge core_clk);
    nibbleMode = nib;
    codeEnable = code;
    repeat (8) @(negedge core_clk);
  endtask : mode

  // every word the partner captured must match the oldest expectation
  always @(negedge reference_clock_in) if (gotStb === 1'b1) checkWord(gotWord, expQ.pop_front());

  task automatic t_mux_raw();
    mode(1'b0, 1'b0);
    send({10'h2A5, 10'h15A, 10'h3C3, 10'h0F0, 10'h255, 10'h1AA});
    drain();
  endtask : t_mux_raw
  task automatic t_mux_code();
    mode(1'b0, 1'b1);
    send({10'h3BC, 10'h2F7, 10'h3BC, 10'h3F7, 10'h2AA, 10'h355});
    drain();
  endtask : t_mux_code
  task automatic t_nib_raw();
    mode(1'b1, 1'b0);
    send({10'h31E, 10'h0E1, 10'h21B, 10'h1D4, 10'h318, 10'h0E7});
    drain();
  endtask : t_nib_raw
  task automatic t_nib_code();
    mode(1'b1, 1'b1);
    send({10'h3DC, 10'h15B, 10'h1FA, 10'h3DD, 10'h2F5, 10'h19E});
    drain();
  endtask : t_nib_code
  // back to back words fill the buffer; none may be lost or reordered
  task automatic t_burst();
    mode(1'b0, 1'b0);
    sawFull = 1'b0;
    for (int i = 0; i < 6; i++) send(60'h012_3456_789A_BCDE + 60'(i) * 60'h004_0100_4010_0401);
    drain();
    checkBit(sawFull, "buffer never refused");
  endtask : t_burst

  task automatic summarize();
    $display("errors %0d comparisons %0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      nErrors++;
      summarize();
    end
  end

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    rxValid = 1'b0;
    rxWords = '0;
    nibbleMode = 1'b0;
    codeEnable = 1'b0;
    sawFull = 1'b0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_mux_raw();
    t_mux_code();
    t_nib_raw();
    t_nib_code();
    t_burst();
    summarize();
  end
endmodule : rdm_rx_ddr_map_tb
`default_nettype wire
